// [mmu_pkg.sv]
// memory map unit constants, field layout and target kinds
// Operation
// - reads where ROM overlays RAM return the ROM byte
// - writes where ROM overlays RAM go to the RAM beneath
// - two RAM banks of 64K each, 128K in total
// - one RAM bank at a time fills the 16-bit address space
// - mapping follows only the current configuration register value
// - configurations 0 to 3 are RAM only
// - configurations 4 to 7 show internal ROM and I/O over RAM
// - configurations 8 to 11 show external ROM and I/O over RAM
// - configuration 12: OS ROM, low internal ROM, I/O, bank 0
// - configuration 13: OS ROM, low external ROM, I/O, bank 0
// - configuration 14: OS and interpreter ROM, character ROM, bank 0
// - configuration 15: OS and interpreter ROM, I/O, bank 0
// - configurations 0,2,4,6,8,10,12-15 share the same RAM bank
// - preset register held; load strobe write copies it to configuration
// - interpreter ROM removed (bit 1) makes 4000-7FFF plain RAM; 8000-BFFF follows bits 2 and 3
// - I/O region D000-DFFF can be removed and restored
// - bit 6 picks RAM bank (one bank bit by default), apart from bits 0 to 5
package mmu_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [15:0] MMU_PRESET_A_ADDR  = 16'hd501;
    localparam logic [15:0] MMU_CFG_ADDR       = 16'hff00;
    localparam logic [15:0] MMU_LOAD_A_ADDR    = 16'hff01;

    ////////////////////////////////////////////////////////////////////////
    // configuration field layout
    localparam int MMU_IO_OFF_BIT = 0;
    localparam int MMU_LO_RAM_BIT = 1;
    localparam int MMU_MID_LSB    = 2;
    localparam int MMU_HI_LSB     = 4;
    localparam int MMU_BANK_LSB   = 6;

    // upper ROM field codes
    localparam logic [1:0] MMU_SEL_SYS = 2'h0;
    localparam logic [1:0] MMU_SEL_INT = 2'h1;
    localparam logic [1:0] MMU_SEL_EXT = 2'h2;
    localparam logic [1:0] MMU_SEL_RAM = 2'h3;

    // address windows, top two address bits; I/O window by top nibble
    localparam logic [1:0] MMU_REG_LO  = 2'h1;
    localparam logic [1:0] MMU_REG_MID = 2'h2;
    localparam logic [1:0] MMU_REG_HI  = 2'h3;
    localparam logic [3:0] MMU_IO_NIB  = 4'hd;

    ////////////////////////////////////////////////////////////////////////
    // register values of the sixteen default configurations
    localparam logic [7:0] MMU_CFG_TABLE [16] = '{
        8'h3f, 8'h7f, 8'hbf, 8'hff,
        8'h16, 8'h56, 8'h96, 8'hd6,
        8'h2a, 8'h6a, 8'haa, 8'hea,
        8'h06, 8'h0a, 8'h01, 8'h00
    };

    // reset: configuration 15
    localparam logic [7:0] MMU_CFG_RESET    = 8'h00;
    localparam logic [7:0] MMU_PRESET_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // what an access reaches
    typedef enum logic [2:0] {
        MMU_T_RAM,
        MMU_T_INTERP,
        MMU_T_SYS,
        MMU_T_INT,
        MMU_T_EXT,
        MMU_T_CHAR,
        MMU_T_IO,
        MMU_T_REG
    } mmu_target_type;

endpackage

// [mmu_decode.sv]
// memory map unit address decoder
`timescale 1ns/1ps
module mmu_decode (
    input  wire logic [7:0]          cfg,
    input  wire logic [15:0]         addr,
    input  wire logic                is_write,
    output mmu_pkg::mmu_target_type  target
);

    ////////////////////////////////////////////////////////////////////////
    // configuration fields
    logic       io_off;
    logic       lo_ram;
    logic [1:0] mid_sel;
    logic [1:0] hi_sel;
    logic       io_hit;
    logic       reg_hit;

    assign io_off  = cfg[mmu_pkg::MMU_IO_OFF_BIT];
    assign lo_ram  = cfg[mmu_pkg::MMU_LO_RAM_BIT];
    assign mid_sel = cfg[mmu_pkg::MMU_MID_LSB +: 2];
    assign hi_sel  = cfg[mmu_pkg::MMU_HI_LSB +: 2];
    assign io_hit  = addr[15:12] == mmu_pkg::MMU_IO_NIB;
    assign reg_hit = addr == mmu_pkg::MMU_CFG_ADDR
                  || addr == mmu_pkg::MMU_LOAD_A_ADDR;

    ////////////////////////////////////////////////////////////////////////
    // region decode, from config only
    mmu_pkg::mmu_target_type rd_t;

    always_comb begin
        rd_t = mmu_pkg::MMU_T_RAM;
        if (reg_hit) begin
            rd_t = mmu_pkg::MMU_T_REG;
        end else if (addr[15:14] == mmu_pkg::MMU_REG_LO) begin
            if (!lo_ram) begin
                rd_t = mmu_pkg::MMU_T_INTERP;
            end
        end else if (addr[15:14] == mmu_pkg::MMU_REG_MID) begin
            case (mid_sel)
                mmu_pkg::MMU_SEL_SYS: rd_t = mmu_pkg::MMU_T_INTERP;
                mmu_pkg::MMU_SEL_INT: rd_t = mmu_pkg::MMU_T_INT;
                mmu_pkg::MMU_SEL_EXT: rd_t = mmu_pkg::MMU_T_EXT;
                default:              rd_t = mmu_pkg::MMU_T_RAM;
            endcase
        end else if (addr[15:14] == mmu_pkg::MMU_REG_HI) begin
            if (io_hit && !io_off) begin
                if (addr == mmu_pkg::MMU_PRESET_A_ADDR) begin
                    rd_t = mmu_pkg::MMU_T_REG;
                end else begin
                    rd_t = mmu_pkg::MMU_T_IO;
                end
            end else if (io_hit && hi_sel != mmu_pkg::MMU_SEL_RAM) begin
                rd_t = mmu_pkg::MMU_T_CHAR;
            end else begin
                case (hi_sel)
                    mmu_pkg::MMU_SEL_SYS: rd_t = mmu_pkg::MMU_T_SYS;
                    mmu_pkg::MMU_SEL_INT: rd_t = mmu_pkg::MMU_T_INT;
                    mmu_pkg::MMU_SEL_EXT: rd_t = mmu_pkg::MMU_T_EXT;
                    default:              rd_t = mmu_pkg::MMU_T_RAM;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // writes through any ROM land in RAM
    always_comb begin
        target = rd_t;
        if (is_write && rd_t != mmu_pkg::MMU_T_IO
                && rd_t != mmu_pkg::MMU_T_REG) begin
            target = mmu_pkg::MMU_T_RAM;
        end
    end

endmodule // mmu_decode

// [mmu_top.sv]
// memory map unit: configuration registers and access steering
`timescale 1ns/1ps
module mmu_top #(
    parameter int RAM_BANK_BITS = 1
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic [15:0]                   cpu_addr,
    input  wire logic [7:0]                    cpu_wdata,
    input  wire logic                          cpu_rd,
    input  wire logic                          cpu_wr,
    output logic [7:0]                         cpu_rdata,
    output logic                               cpu_rdata_valid,
    output logic [15+RAM_BANK_BITS:0]          ram_addr,
    output logic                               ram_rd,
    output logic                               ram_wr,
    input  wire logic [7:0]                    ram_rdata,
    output logic [15:0]                        rom_addr,
    output logic                               rom_rd,
    output mmu_pkg::mmu_target_type            rom_kind,
    input  wire logic [7:0]                    rom_rdata,
    output logic [11:0]                        io_addr,
    output logic                               io_rd,
    output logic                               io_wr,
    input  wire logic [7:0]                    io_rdata,
    output logic [7:0]                         dev_wdata,
    output logic [7:0]                         config_value,
    output logic [RAM_BANK_BITS-1:0]           ram_bank
);

    ////////////////////////////////////////////////////////////////////////
    // request decode
    logic                    req;
    mmu_pkg::mmu_target_type tgt;

    assign req = cpu_rd | cpu_wr;

    logic [7:0] config_q;
    logic [7:0] config_d;
    logic [7:0] preset_q;
    logic [7:0] preset_d;

    mmu_decode u_decode (
        .cfg      (config_q),
        .addr     (cpu_addr),
        .is_write (cpu_wr),
        .target   (tgt)
    );

    logic hit_cfg;
    logic hit_load;
    logic hit_preset;
    logic reg_acc;

    assign reg_acc    = req && tgt == mmu_pkg::MMU_T_REG;
    assign hit_cfg    = reg_acc && cpu_addr == mmu_pkg::MMU_CFG_ADDR;
    assign hit_load   = reg_acc && cpu_addr == mmu_pkg::MMU_LOAD_A_ADDR;
    assign hit_preset = reg_acc && cpu_addr == mmu_pkg::MMU_PRESET_A_ADDR;

    ////////////////////////////////////////////////////////////////////////
    // configuration and preset registers
    always_comb begin
        config_d = config_q;
        preset_d = preset_q;
        if (cpu_wr && hit_preset) begin
            preset_d = cpu_wdata;
        end
        if (cpu_wr && hit_cfg) begin
            config_d = cpu_wdata;
        end else if (cpu_wr && hit_load) begin
            config_d = preset_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            config_q <= mmu_pkg::MMU_CFG_RESET;
            preset_q <= mmu_pkg::MMU_PRESET_RESET;
        end else begin
            config_q <= config_d;
            preset_q <= preset_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read value
    logic [7:0] reg_rdata;

    always_comb begin
        reg_rdata = 8'h00;
        if (hit_cfg) begin
            reg_rdata = config_q;
        end else if (hit_load || hit_preset) begin
            reg_rdata = preset_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stage one: strobes to the memories and I/O
    logic [15+RAM_BANK_BITS:0] ram_addr_q;
    logic [15+RAM_BANK_BITS:0] ram_addr_d;
    logic                      ram_rd_q;
    logic                      ram_rd_d;
    logic                      ram_wr_q;
    logic                      ram_wr_d;
    logic [15:0]               rom_addr_q;
    logic [15:0]               rom_addr_d;
    logic                      rom_rd_q;
    logic                      rom_rd_d;
    mmu_pkg::mmu_target_type   tgt_q;
    mmu_pkg::mmu_target_type   tgt_d;
    logic [11:0]               io_addr_q;
    logic [11:0]               io_addr_d;
    logic                      io_rd_q;
    logic                      io_rd_d;
    logic                      io_wr_q;
    logic                      io_wr_d;
    logic [7:0]                wdata_q;
    logic [7:0]                wdata_d;
    logic                      rd_pend_q;
    logic                      rd_pend_d;
    logic [7:0]                reg_hold_q;
    logic [7:0]                reg_hold_d;
    logic [RAM_BANK_BITS-1:0]  bank;

    // bank field apart from ROM fields
    assign bank = config_q[mmu_pkg::MMU_BANK_LSB +: RAM_BANK_BITS];

    always_comb begin
        ram_addr_d = ram_addr_q;
        ram_rd_d   = 1'b0;
        ram_wr_d   = 1'b0;
        rom_addr_d = rom_addr_q;
        rom_rd_d   = 1'b0;
        tgt_d      = tgt_q;
        io_addr_d  = io_addr_q;
        io_rd_d    = 1'b0;
        io_wr_d    = 1'b0;
        wdata_d    = wdata_q;
        rd_pend_d  = cpu_rd;
        reg_hold_d = reg_hold_q;
        if (req) begin
            tgt_d = tgt;
            if (cpu_wr) begin
                wdata_d = cpu_wdata;
            end
            case (tgt)
                mmu_pkg::MMU_T_RAM: begin
                    // one bank fills the space
                    ram_addr_d = {bank, cpu_addr};
                    ram_rd_d   = cpu_rd;
                    ram_wr_d   = cpu_wr;
                end
                mmu_pkg::MMU_T_IO: begin
                    io_addr_d = cpu_addr[11:0];
                    io_rd_d   = cpu_rd;
                    io_wr_d   = cpu_wr;
                end
                mmu_pkg::MMU_T_REG: begin
                    reg_hold_d = reg_rdata;
                end
                default: begin
                    rom_addr_d = cpu_addr;
                    rom_rd_d   = cpu_rd;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ram_addr_q <= '0;
            ram_rd_q   <= 1'b0;
            ram_wr_q   <= 1'b0;
            rom_addr_q <= 16'h0000;
            rom_rd_q   <= 1'b0;
            tgt_q      <= mmu_pkg::MMU_T_RAM;
            io_addr_q  <= 12'h000;
            io_rd_q    <= 1'b0;
            io_wr_q    <= 1'b0;
            wdata_q    <= 8'h00;
            rd_pend_q  <= 1'b0;
            reg_hold_q <= 8'h00;
        end else begin
            ram_addr_q <= ram_addr_d;
            ram_rd_q   <= ram_rd_d;
            ram_wr_q   <= ram_wr_d;
            rom_addr_q <= rom_addr_d;
            rom_rd_q   <= rom_rd_d;
            tgt_q      <= tgt_d;
            io_addr_q  <= io_addr_d;
            io_rd_q    <= io_rd_d;
            io_wr_q    <= io_wr_d;
            wdata_q    <= wdata_d;
            rd_pend_q  <= rd_pend_d;
            reg_hold_q <= reg_hold_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stage two: capture the answer of the selected source
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       valid_q;
    logic       valid_d;

    always_comb begin
        rdata_d = rdata_q;
        valid_d = rd_pend_q;
        if (rd_pend_q) begin
            case (tgt_q)
                mmu_pkg::MMU_T_RAM: rdata_d = ram_rdata;
                mmu_pkg::MMU_T_IO:  rdata_d = io_rdata;
                mmu_pkg::MMU_T_REG: rdata_d = reg_hold_q;
                default:            rdata_d = rom_rdata;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
            valid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            valid_q <= valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign cpu_rdata       = rdata_q;
    assign cpu_rdata_valid = valid_q;
    assign ram_addr        = ram_addr_q;
    assign ram_rd          = ram_rd_q;
    assign ram_wr          = ram_wr_q;
    assign rom_addr        = rom_addr_q;
    assign rom_rd          = rom_rd_q;
    assign rom_kind        = tgt_q;
    assign io_addr         = io_addr_q;
    assign io_rd           = io_rd_q;
    assign io_wr           = io_wr_q;
    assign dev_wdata       = wdata_q;
    assign config_value    = config_q;
    assign ram_bank        = bank;

endmodule // mmu_top

// [mmu_chk.sv]
// assertion checker for the memory map unit ports
`timescale 1ns/1ps
module mmu_chk #(
    parameter int RAM_BANK_BITS = 1
) (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic [15:0]             cpu_addr,
    input wire logic [7:0]              cpu_wdata,
    input wire logic                    cpu_rd,
    input wire logic                    cpu_wr,
    input wire logic [7:0]              cpu_rdata,
    input wire logic                    cpu_rdata_valid,
    input wire logic [15+RAM_BANK_BITS:0] ram_addr,
    input wire logic                    ram_rd,
    input wire logic                    ram_wr,
    input wire logic [7:0]              ram_rdata,
    input wire logic                    rom_rd,
    input wire mmu_pkg::mmu_target_type rom_kind,
    input wire logic [11:0]             io_addr,
    input wire logic                    io_rd,
    input wire logic                    io_wr,
    input wire logic [7:0]              dev_wdata,
    input wire logic [7:0]              config_value
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    sequence s_set;
        cpu_wr && cpu_addr == 16'hd501 && !config_value[0];
    endsequence
    sequence s_load;
        cpu_wr && cpu_addr == 16'hff01;
    endsequence
    ////////////////////////////////////////
    AST_RD_ANSWER: assert property (
        cpu_rd |-> ##2 cpu_rdata_valid) else $error("read unanswered");
    AST_VALID_CAUSE: assert property (
        cpu_rdata_valid |-> $past(cpu_rd, 2)) else $error("stray valid");
    AST_RAM_DATA: assert property (
        cpu_rdata_valid && $past(ram_rd) |-> cpu_rdata == $past(ram_rdata))
        else $error("ram byte lost");
    AST_ROM_INTERP: assert property (
        cpu_rd && cpu_addr[15:14] == 2'h1 && !config_value[1] |=>
        rom_rd && rom_kind == mmu_pkg::MMU_T_INTERP)
        else $error("low rom not read");
    AST_WR_BLEED: assert property (
        cpu_wr && cpu_addr < 16'hd000 |=> ram_wr && !rom_rd &&
        dev_wdata == $past(cpu_wdata) && ram_addr[15:0] == $past(cpu_addr))
        else $error("write missed ram");
    AST_RAM_ONLY: assert property (
        cpu_rd && config_value[5:0] == 6'h3f && cpu_addr < 16'hff00 |=>
        ram_rd && ram_addr[15:0] == $past(cpu_addr))
        else $error("ram only map broken");
    AST_BANK: assert property (
        ram_rd || ram_wr |-> ram_addr[16 +: RAM_BANK_BITS] ==
        $past(config_value[6 +: RAM_BANK_BITS])) else $error("bad bank");
    AST_IO_MAP: assert property (
        (cpu_rd || cpu_wr) && cpu_addr[15:12] == 4'hd &&
        cpu_addr != 16'hd501 && !config_value[0] &&
        config_value[5:4] != 2'h3 |=> (io_rd || io_wr) &&
        io_addr == $past(cpu_addr[11:0])) else $error("io not reached");
    AST_CHAR: assert property (
        cpu_rd && cpu_addr[15:12] == 4'hd && config_value[0] &&
        config_value[5:4] != 2'h3 |=>
        rom_rd && rom_kind == mmu_pkg::MMU_T_CHAR) else $error("no char");
    AST_DIRECT_CFG: assert property (
        cpu_wr && cpu_addr == 16'hff00 |=>
        config_value == $past(cpu_wdata)) else $error("cfg not loaded");
    AST_PRESET: assert property (
        s_set ##1 !cpu_wr ##1 s_load |=>
        config_value == $past(cpu_wdata, 3))
        else $error("preset not copied");
    AST_ONE_DEV: assert property (
        $onehot0({ram_rd, rom_rd, io_rd, ram_wr, io_wr}))
        else $error("two targets at once");
endmodule // mmu_chk

bind mmu_top mmu_chk #(.RAM_BANK_BITS(RAM_BANK_BITS)) u_chk (
    .clk, .rst, .cpu_addr, .cpu_wdata, .cpu_rd, .cpu_wr, .cpu_rdata,
    .cpu_rdata_valid, .ram_addr, .ram_rd, .ram_wr, .ram_rdata, .rom_rd,
    .rom_kind, .io_addr, .io_rd, .io_wr, .dev_wdata, .config_value);

// [mmu_mem_model.sv]
// ram, rom and i/o model behind the memory map unit
`timescale 1ns/1ps
module mmu_mem_model (
    input  wire logic        clk,
    input  wire logic [16:0] ram_addr,
    input  wire logic        ram_rd,
    input  wire logic        ram_wr,
    input  wire logic [7:0]  dev_wdata,
    output logic [7:0]       ram_rdata,
    input  wire logic [15:0] rom_addr,
    input  wire logic        rom_rd,
    output logic [7:0]       rom_rdata,
    input  wire logic [11:0] io_addr,
    input  wire logic        io_rd,
    output logic [7:0]       io_rdata
);
    logic [7:0] mem [131072]; // two 64k banks
    logic [7:0] junk_q = 8'h5a;
    // known contents so ram reads never return unknowns
    initial begin
        for (int i = 0; i < 131072; i++) begin
            mem[i] = 8'h00;
        end
    end
    always @(posedge clk) begin
        junk_q <= ~junk_q + 8'h01;
        if (ram_wr) begin
            mem[ram_addr] <= dev_wdata;
        end
    end
    // answers only in the strobe cycle
    assign ram_rdata = ram_rd ? mem[ram_addr] : junk_q;
    assign rom_rdata = rom_rd ? rom_addr[7:0] ^ 8'hc3 : junk_q;
    assign io_rdata  = io_rd ? io_addr[7:0] ^ 8'h96 : junk_q;
endmodule // mmu_mem_model

// [tb_top.sv]
// self-checking bench for the memory map unit
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0]  cpu_wdata = 8'h00;
    logic        cpu_rd = 1'b0;
    logic        cpu_wr = 1'b0;
    logic [7:0]  cpu_rdata, ram_rdata, rom_rdata, io_rdata, dev_wdata;
    logic [7:0]  config_value, wd, rd;
    logic        cpu_rdata_valid, ram_rd, ram_wr, rom_rd, io_rd, io_wr;
    logic [16:0] ram_addr, raddr;
    logic [15:0] rom_addr;
    logic [11:0] io_addr, iaddr;
    logic [0:0]  ram_bank;
    logic [4:0]  strb;
    mmu_pkg::mmu_target_type rom_kind, kd;
    int          failures = 0;
    int          check_count = 0;
    int          cyc = 0;
    localparam logic [4:0] S_RAM = 5'h10, S_ROM = 5'h08, S_IO = 5'h04;
    localparam logic [4:0] S_RWR = 5'h02, S_IWR = 5'h01;

    mmu_top uut (.clk, .rst, .cpu_addr, .cpu_wdata, .cpu_rd, .cpu_wr,
        .cpu_rdata, .cpu_rdata_valid, .ram_addr, .ram_rd, .ram_wr,
        .ram_rdata, .rom_addr, .rom_rd, .rom_kind, .rom_rdata, .io_addr,
        .io_rd, .io_wr, .io_rdata, .dev_wdata, .config_value, .ram_bank);
    mmu_mem_model u_mem (.clk, .ram_addr, .ram_rd, .ram_wr, .dev_wdata,
        .ram_rdata, .rom_addr, .rom_rd, .rom_rdata, .io_addr, .io_rd,
        .io_rdata);

    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            complete_run();
        end
    end
    ////////////////////////////////////////
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one access, strobes caught in the cycle after
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        @(negedge clk);
        cpu_wr = w;
        cpu_rd = !w;
        cpu_addr = a;
        cpu_wdata = d;
        @(negedge clk);
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        strb = {ram_rd, rom_rd, io_rd, ram_wr, io_wr};
        raddr = ram_addr;
        iaddr = io_addr;
        wd = dev_wdata;
        kd = rom_kind;
        if (!w) begin
            @(negedge clk);
            chk(cpu_rdata_valid, 1'b1);
            rd = cpu_rdata;
        end
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        chk(config_value, 8'h00);
        acc(1'b0, 16'hff00, 8'h00);
        chk({strb, rd}, 13'h0000);
    endtask
    task automatic t_table();
        logic [4:0] e;
        for (int i = 0; i < 16; i++) begin
            acc(1'b1, 16'hff00, mmu_pkg::MMU_CFG_TABLE[i]);
            chk(config_value, mmu_pkg::MMU_CFG_TABLE[i]);
            chk(ram_bank, (i < 12) ? i % 2 : 0);
            acc(1'b0, 16'h8000, 8'h00);
            chk(strb, (i < 4) ? S_RAM : S_ROM);
            acc(1'b0, 16'hd000, 8'h00);
            e = (i == 14) ? S_ROM : S_IO;
            chk(strb, (i < 4) ? S_RAM : e);
            if (i == 14) chk(kd, mmu_pkg::MMU_T_CHAR);
            acc(1'b0, 16'h4000, 8'h00);
            chk(strb, (i > 13) ? S_ROM : S_RAM);
        end
    endtask
    task automatic t_overlay();
        acc(1'b1, 16'hff00, 8'h3f);
        acc(1'b1, 16'h8000, 8'h5a);
        chk(raddr, 17'h08000);
        acc(1'b1, 16'hff00, 8'h00);
        acc(1'b0, 16'h8000, 8'h00);
        chk({strb, rd}, {S_ROM, 8'hc3});
        acc(1'b1, 16'h8000, 8'ha5);
        chk({strb, wd}, {S_RWR, 8'ha5});
        acc(1'b1, 16'hff00, 8'h7f);
        acc(1'b1, 16'h8000, 8'h3c);
        chk(raddr, 17'h18000);
        acc(1'b0, 16'h8000, 8'h00);
        chk(rd, 8'h3c);
        acc(1'b1, 16'hff00, 8'h3f);
        acc(1'b0, 16'h8000, 8'h00);
        chk(rd, 8'ha5);
    endtask
    task automatic t_preset();
        acc(1'b1, 16'hff00, 8'h00);
        acc(1'b1, 16'hd501, 8'h0e);
        chk({strb, config_value}, 13'h0000);
        acc(1'b1, 16'hff01, 8'h00);
        chk(config_value, 8'h0e);
        acc(1'b0, 16'hd501, 8'h00);
        chk(rd, 8'h0e);
        acc(1'b0, 16'h4000, 8'h00);
        chk(strb, S_RAM);
        acc(1'b0, 16'hbfff, 8'h00);
        chk(strb, S_RAM);
        acc(1'b1, 16'hff00, 8'h01);
        acc(1'b0, 16'hd000, 8'h00);
        chk(strb, S_ROM);
        acc(1'b1, 16'hff00, 8'h00);
        acc(1'b1, 16'hd020, 8'h77);
        chk({strb, iaddr}, {S_IWR, 12'h020});
        acc(1'b0, 16'hd020, 8'h00);
        chk({strb, rd}, {S_IO, 8'hb6});
    endtask
    task automatic t_b2b();
        @(negedge clk);
        cpu_wr = 1'b1;
        cpu_addr = 16'hff00;
        cpu_wdata = 8'h3f;
        @(negedge clk);
        cpu_wr = 1'b0;
        cpu_rd = 1'b1;
        cpu_addr = 16'hc000;
        @(negedge clk);
        cpu_rd = 1'b0;
        chk(ram_rd, 1'b1);
        @(negedge clk);
    endtask
    ////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_table();
        t_overlay();
        t_preset();
        t_b2b();
        complete_run();
    end
endmodule // tb_top
